/* File: verilog/apmc_params.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef APMC_PARAMS_SVH
`define APMC_PARAMS_SVH
`define APMC_OFS_INACT_THRESH 8'h25
`define APMC_OFS_INACT_TIME   8'h26
`define APMC_OFS_RATE_SEL     8'h2c
`define APMC_OFS_POWER_CONTROL    8'h2d
`define APMC_BIT_LOW_POWER    4
`define APMC_BIT_AUTOSLEEP    4
`define APMC_BIT_LINK         5
`define APMC_BIT_MEASURE      3
`define APMC_RST_INACT_THRESH 8'h00
`define APMC_RST_INACT_TIME   8'h00
`define APMC_RST_RATE_SEL     8'h0a
`define APMC_RST_POWER_CONTROL    8'h00
`define APMC_CLK_HZ           25000000
`define APMC_SECOND_NS        1000000000
`define APMC_CLK_PERIOD_NS    40
`define APMC_SECOND_CYCLES    (`APMC_SECOND_NS / `APMC_CLK_PERIOD_NS)
`endif

/* File: verilog/apmc_pkg.sv */
// Types for the accelerometer power mode control block
package apmc_pkg;
   typedef enum logic [1:0] {
      APMC_STANDBY,
      APMC_MEASURE,
      APMC_SLEEP
   } apmc_mode_t;
endpackage

/* File: verilog/apmc_power_mode.sv */
// Power mode control: registers, mode machine, rate decode, autosleep timer
`timescale 1ns/1ps
`include "apmc_params.svh"

module apmc_power_mode
   import apmc_pkg::*;
#(
   parameter int SECOND_CYCLES = `APMC_SECOND_CYCLES
) (
   input  wire logic       clock_i,
   input  wire logic       resetn_i,
   input  wire logic       reg_wr_i,
   input  wire logic       reg_rd_i,
   input  wire logic [7:0] reg_addr_i,
   input  wire logic [7:0] reg_wdata_i,
   output logic      [7:0] reg_rdata_o,
   input  wire logic       sample_valid_i,
   input  wire logic [7:0] sample_mag_i,
   output logic      [1:0] mode_o,
   output logic            sense_en_o,
   output logic            fifo_hold_o,
   output logic      [3:0] rate_code_o,
   output logic            low_power_o,
   output logic      [4:0] odr_shift_o,
   output logic            odr_valid_o
);

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic [7:0]  thresh_reg;
   logic [7:0]  time_reg;
   logic [7:0]  rate_reg;
   logic [7:0]  pctl_reg;
   logic [7:0]  rdata_reg;
   apmc_mode_t  mode_reg;
   apmc_mode_t  mode_next;
   logic [31:0] tick_reg;
   logic [7:0]  secs_reg;

   wire sel_thresh = reg_addr_i == `APMC_OFS_INACT_THRESH;
   wire sel_time   = reg_addr_i == `APMC_OFS_INACT_TIME;
   wire sel_rate   = reg_addr_i == `APMC_OFS_RATE_SEL;
   wire sel_pctl   = reg_addr_i == `APMC_OFS_POWER_CONTROL;

   // Writes taken in every mode
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         thresh_reg <= `APMC_RST_INACT_THRESH;
         time_reg   <= `APMC_RST_INACT_TIME;
         rate_reg   <= `APMC_RST_RATE_SEL;
         pctl_reg   <= `APMC_RST_POWER_CONTROL;
      end else if (reg_wr_i) begin
         if (sel_thresh) thresh_reg <= reg_wdata_i;
         if (sel_time)   time_reg   <= reg_wdata_i;
         if (sel_rate)   rate_reg   <= reg_wdata_i;
         if (sel_pctl)   pctl_reg   <= reg_wdata_i;
      end
   end

   wire [7:0] rdata_next = sel_thresh ? thresh_reg :
                           sel_time   ? time_reg   :
                           sel_rate   ? rate_reg   :
                           sel_pctl   ? pctl_reg   : 8'h00;

   // Read data registered one cycle after the strobe
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rdata_reg <= 8'h00;
      end else if (reg_rd_i) begin
         rdata_reg <= rdata_next;
      end
   end
   assign reg_rdata_o = rdata_reg;

   // ----------------------------------------------------------------
   // Mode machine
   // ----------------------------------------------------------------
   wire measure_bit = pctl_reg[`APMC_BIT_MEASURE];
   wire armed = pctl_reg[`APMC_BIT_AUTOSLEEP] & pctl_reg[`APMC_BIT_LINK];
   wire active = sample_valid_i & (sample_mag_i >= thresh_reg);
   wire timer_run = (mode_reg == APMC_MEASURE) & armed;
   wire sec_tick = tick_reg == 32'(SECOND_CYCLES - 1);
   wire expired = timer_run & (secs_reg >= time_reg);

   always_comb begin
      mode_next = mode_reg;
      case (mode_reg)
         APMC_STANDBY: if (measure_bit) mode_next = APMC_MEASURE;
         APMC_MEASURE: begin
            if (!measure_bit) mode_next = APMC_STANDBY;
            else if (expired && !active) mode_next = APMC_SLEEP;
         end
         APMC_SLEEP: begin
            if (!measure_bit) mode_next = APMC_STANDBY;
            else if (!armed) mode_next = APMC_MEASURE;
         end
         default: mode_next = APMC_STANDBY;
      endcase
   end

   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) mode_reg <= APMC_STANDBY;
      else mode_reg <= mode_next;
   end

   // Inactivity timer in whole seconds
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         tick_reg <= 32'h0;
         secs_reg <= 8'h00;
      end else if (!timer_run || active) begin
         tick_reg <= 32'h0;
         secs_reg <= 8'h00;
      end else if (sec_tick) begin
         tick_reg <= 32'h0;
         if (secs_reg != 8'hff) secs_reg <= secs_reg + 8'h01;
      end else begin
         tick_reg <= tick_reg + 32'h1;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   wire [3:0] code = rate_reg[3:0];
   assign mode_o      = mode_reg;
   assign sense_en_o  = mode_reg == APMC_MEASURE;
   assign fifo_hold_o = mode_reg != APMC_MEASURE;
   assign rate_code_o = code;
   assign low_power_o = rate_reg[`APMC_BIT_LOW_POWER];
   // Output rate is 3200 Hz shifted right by this; bandwidth one more
   assign odr_valid_o = code >= 4'h6;
   assign odr_shift_o = odr_valid_o ? {1'b0, 4'hf - code} : 5'h00;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   a_standby_sense_off: assert property (@(posedge clock_i) disable iff (!resetn_i)
      mode_reg == APMC_STANDBY |-> !sense_en_o) else $error("sensing on in standby");
   a_measure_entry: assert property (@(posedge clock_i) disable iff (!resetn_i)
      (mode_reg == APMC_STANDBY && measure_bit) |=> sense_en_o)
      else $error("measure not entered");
   a_measure_exit: assert property (@(posedge clock_i) disable iff (!resetn_i)
      !measure_bit |=> mode_reg == APMC_STANDBY) else $error("standby not entered");
   a_sleep_needs_arm: assert property (@(posedge clock_i) disable iff (!resetn_i)
      $rose(mode_reg == APMC_SLEEP) |-> $past(armed)) else $error("sleep without arm");
   a_timer_restart: assert property (@(posedge clock_i) disable iff (!resetn_i)
      active |=> secs_reg == 8'h00 && tick_reg == 32'h0) else $error("timer not cleared");
   a_odr_decode: assert property (@(posedge clock_i) disable iff (!resetn_i)
      code == 4'hf |-> odr_shift_o == 5'h00 && odr_valid_o) else $error("rate decode");
   a_reg_retain: assert property (@(posedge clock_i) disable iff (!resetn_i)
      (!reg_wr_i && mode_reg != mode_next) |=> $stable(thresh_reg) && $stable(time_reg))
      else $error("register lost on mode change");
   a_low_power_bit: assert property (@(posedge clock_i) disable iff (!resetn_i)
      (reg_wr_i && sel_rate) |=> low_power_o == $past(reg_wdata_i[`APMC_BIT_LOW_POWER]))
      else $error("low power bit");
   a_fifo_hold: assert property (@(posedge clock_i) disable iff (!resetn_i)
      fifo_hold_o == !sense_en_o) else $error("fifo hold");

   // Steps of the autosleep path
   sequence s_sleep_due;
      mode_reg == APMC_MEASURE && measure_bit && expired && !active;
   endsequence

   sequence s_asleep;
      mode_reg == APMC_SLEEP;
   endsequence

   sequence s_timer_clear;
      secs_reg == 8'h00 && tick_reg == 32'h0;
   endsequence

   a_sleep_entry: assert property (@(posedge clock_i) disable iff (!resetn_i)
      s_sleep_due |=> s_asleep) else $error("sleep not entered");
   a_sleep_full_time: assert property (@(posedge clock_i) disable iff (!resetn_i)
      $rose(mode_reg == APMC_SLEEP) |-> $past(expired)) else $error("sleep too early");
   a_sleep_disarm: assert property (@(posedge clock_i) disable iff (!resetn_i)
      (mode_reg == APMC_SLEEP && measure_bit && !armed) |=> mode_reg == APMC_MEASURE)
      else $error("sleep not left on disarm");
   a_timer_disable: assert property (@(posedge clock_i) disable iff (!resetn_i)
      !timer_run |=> s_timer_clear) else $error("timer not held");
   a_second_step: assert property (@(posedge clock_i) disable iff (!resetn_i)
      (timer_run && !active && sec_tick && secs_reg != 8'hff) |=>
      secs_reg == $past(secs_reg) + 8'h01) else $error("second not counted");
   a_tick_bound: assert property (@(posedge clock_i) disable iff (!resetn_i)
      tick_reg < 32'(SECOND_CYCLES)) else $error("tick out of range");
   a_read_data: assert property (@(posedge clock_i) disable iff (!resetn_i)
      (reg_rd_i && sel_pctl) |=> reg_rdata_o == $past(pctl_reg))
      else $error("read data");
   a_unmapped_read: assert property (@(posedge clock_i) disable iff (!resetn_i)
      (reg_rd_i && !(sel_thresh || sel_time || sel_rate || sel_pctl)) |=>
      reg_rdata_o == 8'h00) else $error("unmapped read");
   a_rdata_hold: assert property (@(posedge clock_i) disable iff (!resetn_i)
      !reg_rd_i |=> $stable(reg_rdata_o)) else $error("read data moved");
   a_write_any_mode: assert property (@(posedge clock_i) disable iff (!resetn_i)
      (reg_wr_i && sel_time) |=> time_reg == $past(reg_wdata_i))
      else $error("write lost");
   a_standby_wait: assert property (@(posedge clock_i) disable iff (!resetn_i)
      (mode_reg == APMC_STANDBY && !measure_bit) |=> mode_reg == APMC_STANDBY)
      else $error("standby left without measure");
   a_rate_range: assert property (@(posedge clock_i) disable iff (!resetn_i)
      odr_valid_o |-> odr_shift_o <= 5'h09) else $error("rate out of range");

endmodule

/* File: dv/apmc_host_model.sv */
// Host model: register strobes and sample stream
`timescale 1ns/1ps
module apmc_host_model (
   input  wire logic       clock_i,
   input  wire logic       act_i,
   input  wire logic [7:0] rdata_i,
   output logic            wr_o,
   output logic            rd_o,
   output logic      [7:0] addr_o,
   output logic      [7:0] wdata_o,
   output logic            valid_o,
   output logic      [7:0] mag_o
);
   initial {wr_o, rd_o, addr_o, wdata_o, valid_o, mag_o} = '0;
   // Quiet samples stay below threshold 8'h40
   always @(posedge clock_i) begin
      valid_o <= 1'b1;
      mag_o   <= act_i ? (8'h40 | 8'($urandom)) : 8'($urandom % 64);
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock_i);
      {wr_o, addr_o, wdata_o} <= {1'b1, a, d};
      @(posedge clock_i);
      wr_o <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clock_i);
      {rd_o, addr_o} <= {1'b1, a};
      @(posedge clock_i);
      rd_o <= 1'b0;
      #1 d = rdata_i;
   endtask
endmodule

/* File: dv/accel_power_mode_control_tb_top.sv */
// Self-checking bench for the power mode control block
`timescale 1ns/1ps
module accel_power_mode_control_tb_top
   import apmc_pkg::*;
;
   logic       clock = 1'b0;
   logic       resetn = 1'b0;
   logic       act = 1'b0;
   logic       wr, rd, valid, sense, hold, lp, ov;
   logic [7:0] addr, wdata, rdata, mag, d, w;
   logic [1:0] mode;
   logic [3:0] code;
   logic [4:0] shift;
   logic [7:0] ofs [4] = '{8'h25, 8'h26, 8'h2c, 8'h2d};
   logic [7:0] rst [4] = '{8'h00, 8'h00, 8'h0a, 8'h00};
   int         n_mismatch = 0;
   int         total_checks = 0;
   always #20 clock = ~clock;
   apmc_host_model host (.clock_i(clock), .act_i(act), .rdata_i(rdata), .wr_o(wr),
      .rd_o(rd), .addr_o(addr), .wdata_o(wdata), .valid_o(valid), .mag_o(mag));
   apmc_power_mode #(.SECOND_CYCLES(10)) uut (.clock_i(clock), .resetn_i(resetn),
      .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata),
      .reg_rdata_o(rdata), .sample_valid_i(valid), .sample_mag_i(mag), .mode_o(mode),
      .sense_en_o(sense), .fifo_hold_o(hold), .rate_code_o(code), .low_power_o(lp),
      .odr_shift_o(shift), .odr_valid_o(ov));
   function automatic logic [7:0] exp_rate(logic [7:0] v);
      return {1'b0, v[4], v[3:0] >= 4'h6, v[3:0] >= 4'h6 ? 5'(5'h0f - v[3:0]) : 5'h00};
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk_mode(input apmc_mode_t m);
      chk({4'h0, mode, sense, hold}, {4'h0, m, m == APMC_MEASURE, m != APMC_MEASURE});
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic wait_mode(input apmc_mode_t m, input int n);
      repeat (n) begin
         @(posedge clock);
         #1 if (mode === m) return;
      end
      chk({6'h00, mode}, {6'h00, m});
      print_verdict();
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   initial begin
      void'($urandom(50));
      cyc(12);
      resetn <= 1'b1;
      chk_mode(APMC_STANDBY);
      foreach (ofs[i]) begin
         host.rd(ofs[i], d);
         chk(d, rst[i]);
      end
      host.rd(8'h30, d);
      chk(d, 8'h00);
      repeat (8) begin
         w = 8'($urandom);
         host.wr(ofs[w[0]], w);
         host.rd(ofs[w[0]], d);
         chk(d, w);
      end
      chk_mode(APMC_STANDBY);
      $display("test registers done");
      for (int c = 0; c < 16; c++) begin
         w = {3'h0, 1'(c >= 7 && c <= 12), 4'(c)};
         host.wr(8'h2c, w);
         #1 chk({3'h0, lp, code}, w);
         chk({1'b0, lp, ov, shift}, exp_rate(w));
      end
      $display("test rate done");
      host.wr(8'h25, 8'h40);
      host.wr(8'h26, 8'h02);
      host.wr(8'h2d, 8'h08);
      cyc(1);
      chk_mode(APMC_MEASURE);
      host.wr(8'h2d, 8'h00);
      cyc(1);
      chk_mode(APMC_STANDBY);
      host.wr(8'h2d, 8'h38);
      cyc(15);
      chk_mode(APMC_MEASURE);
      wait_mode(APMC_SLEEP, 10);
      host.rd(8'h25, d);
      chk(d, 8'h40);
      host.wr(8'h2d, 8'h00);
      act <= 1'b1;
      host.wr(8'h2d, 8'h38);
      cyc(40);
      chk_mode(APMC_MEASURE);
      act <= 1'b0;
      cyc(15);
      chk_mode(APMC_MEASURE);
      wait_mode(APMC_SLEEP, 10);
      host.wr(8'h2d, 8'h08);
      cyc(1);
      chk_mode(APMC_MEASURE);
      $display("test autosleep done");
      foreach (ofs[i]) if (i < 2) begin
         host.wr(8'h2d, 8'h00);
         host.wr(8'h2d, i == 0 ? 8'h18 : 8'h28);
         cyc(60);
         chk_mode(APMC_MEASURE);
      end
      $display("test arming done");
      resetn <= 1'b0;
      cyc(2);
      chk_mode(APMC_STANDBY);
      resetn <= 1'b1;
      host.rd(8'h2d, d);
      chk(d, 8'h00);
      host.rd(8'h2c, d);
      chk(d, 8'h0a);
      cyc(4);
      chk_mode(APMC_STANDBY);
      $display("test reset done");
      print_verdict();
   end
endmodule
